// *** bench/stats_event_src.sv ***
// pipeline side: raises one event source and holds it until taken
module stats_event_src (
   input  wire logic [12:0] ready,
   input  wire logic        clock,
   output logic      [12:0] valid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial valid = '0;
   // ready is combinational, so it is read at the falling edge before the taking edge
   task automatic fire(input int s, input int pre, output bit late);
      int n;
      n = 0;
      repeat (pre + 1) @(posedge clock);
      #1 valid[s] = 1'h1;
      do @(negedge clock); while (ready[s] !== 1'h1 && ++n < 100);
      @(posedge clock);
      #1 valid[s] = 1'h0;
      late = (n >= 100);
   endtask
endmodule

// *** bench/stats_properties.sv ***
module stats_checker (
   input wire logic        clock,
   input wire logic        srst,
   input wire logic        in_drop_valid,
   input wire logic        in_drop_ready,
   input wire logic        eeg_drop_valid,
   input wire logic        eeg_drop_ready,
   input wire logic        eeg_idle_gap,
   input wire logic        acl_valid,
   input wire logic        acl_count_en,
   input wire logic        acl_ready,
   input wire logic        mon_valid,
   input wire logic        mon_ready,
   input wire logic        rd_req,
   input wire logic        rd_ack,
   input wire logic [31:0] rd_data,
   input wire logic        init_busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   gap_after_drop_a: assert property (eeg_drop_valid && eeg_drop_ready |=> eeg_idle_gap)
      else $error("idle gap missing after egress drop");
   gap_has_cause_a: assert property (eeg_idle_gap |-> $past(eeg_drop_valid && eeg_drop_ready))
      else $error("idle gap without egress drop");
   sweep_quiet_a: assert property (init_busy |-> !in_drop_ready && !acl_ready && !mon_ready)
      else $error("event taken during clearing sweep");
   drop_pending_a: assert property (in_drop_valid && in_drop_ready |=> !in_drop_ready)
      else $error("drop source ready while pending");
   acl_pending_a: assert property (acl_valid && acl_count_en && acl_ready |=> !acl_ready)
      else $error("acl source ready while pending");
   mon_two_updates_a: assert property ($fell(mon_ready) |-> !mon_ready [*5])
      else $error("monitor pair finished too early");
   ack_single_a: assert property (rd_ack |=> !rd_ack)
      else $error("read ack longer than one cycle");
   data_hold_a: assert property (!rd_ack |-> $stable(rd_data))
      else $error("read data moved without ack");
   read_answer_a: assert property ($rose(rd_req) && !init_busy |-> ##[3:40] rd_ack)
      else $error("read not answered");
endmodule
bind switch_statistics_counters stats_checker i_stats_checker (.*);

// *** bench/tb_switch_statistics_counters.sv ***
module tb_switch_statistics_counters;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
   $display("Error %0t: got %h expected %h", $time, g, e); end end
   logic clock, srst, ieg_drop_last, acl_count_en, lut_wr, rd_req, eeg_idle_gap, rd_ack, init_busy;
   logic in_drop_valid, ieg_drop_valid, nodest_valid, eeg_drop_valid, acl_valid, mon_valid;
   logic vrf_rx_valid, vrf_tx_valid, nh_valid, iprx_valid, taildrop_valid, head_valid, tail_valid;
   logic in_drop_ready, ieg_drop_ready, nodest_ready, eeg_drop_ready, acl_ready, mon_ready;
   logic vrf_rx_ready, vrf_tx_ready, nh_ready, iprx_ready, taildrop_ready, head_ready, tail_ready;
   logic [5:0] in_drop_reason, ieg_drop_reason, eeg_drop_reason, acl_ptr;
   logic [3:0] ieg_drop_port, eeg_drop_port, mon_port, lut_index, lut_port, iprx_port;
   logic [1:0] lut_set, vrf_rx_id, vrf_tx_id, head_block, tail_block;
   logic [11:0] mon_vid, lut_vid, rd_addr;
   logic [14:0] mon_len;
   logic [9:0] nh_index;
   logic [2:0] mon_pcp, iprx_cat;
   logic [31:0] rd_data;
   logic [12:0] v, r;
   int n_fail = 0;
   int checked = 0;
   assign {tail_valid, head_valid, taildrop_valid, iprx_valid, nh_valid, vrf_tx_valid,
      vrf_rx_valid, mon_valid, acl_valid, eeg_drop_valid, nodest_valid, ieg_drop_valid,
      in_drop_valid} = v;
   assign r = {tail_ready, head_ready, taildrop_ready, iprx_ready, nh_ready, vrf_tx_ready,
      vrf_rx_ready, mon_ready, acl_ready, eeg_drop_ready, nodest_ready, ieg_drop_ready,
      in_drop_ready};
   switch_statistics_counters i_switch_statistics_counters (.*);
   stats_event_src i_stats_event_src (.clock(clock), .ready(r), .valid(v));
   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end
   task automatic conclude();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // pre delays the request, standing in for a slow pipeline stage
   task automatic ev(input int s, input int pre = 0);
      bit late;
      i_stats_event_src.fire(s, pre, late);
      if (late) n_fail++;
   endtask
   // rd_req held until ack is seen at a falling edge; a repeat read may follow, so wait it out
   task automatic rd(input int a, input logic [31:0] e);
      int n;
      n = 0;
      @(posedge clock);
      #1 rd_addr = 12'(a);
      rd_req = 1'h1;
      do @(negedge clock); while (rd_ack !== 1'h1 && ++n < 100);
      @(posedge clock);
      #1 rd_req = 1'h0;
      if (n >= 100) n_fail++;
      `CHK(rd_data, e)
      repeat (5) @(posedge clock);
      #1;
   endtask
   task automatic t_clear();
      rd(stats_pkg::B_IN_DROP, 32'h0);
      rd(stats_pkg::RESET_LAST, 32'h0);
      $display("clear test done");
   endtask
   // boundary reason codes, then a removal that empties the mask plus a plain empty-mask event
   task automatic t_ingress();
      ev(0);
      in_drop_reason = 6'h3f;
      ev(0);
      ieg_drop_last = 1'h1;
      ev(1, 3);
      ev(2);
      rd(stats_pkg::B_IN_DROP, 32'h1);
      rd(stats_pkg::B_IN_DROP + 63, 32'h1);
      rd(stats_pkg::B_IEG_DROP, 32'h1);
      rd(stats_pkg::B_NODEST, 32'h2);
      $display("ingress drop test done");
   endtask
   task automatic t_egress();
      ev(3);
      `CHK(eeg_idle_gap, 1'h1)
      rd(stats_pkg::B_EEG_DROP, 32'h1);
      $display("egress drop test done");
   endtask
   // a non-counting match on the same pointer must leave it alone
   task automatic t_acl();
      acl_ptr = 6'h3f;
      acl_count_en = 1'h1;
      ev(4);
      acl_count_en = 1'h0;
      ev(4);
      rd(stats_pkg::B_ACL + 63, 32'h1);
      $display("acl test done");
   endtask
   // set 3 and pcp 7 sit at the same flat place in either field order
   task automatic t_mon();
      {lut_port, lut_vid, lut_set, lut_wr} = {4'h3, 12'habc, 2'h3, 1'h1};
      @(posedge clock);
      #1 lut_wr = 1'h0;
      {mon_port, mon_vid, mon_pcp, mon_len} = {4'h3, 12'habc, 3'h7, 15'h5dc};
      ev(5);
      mon_vid = 12'habd;
      ev(5);
      rd(stats_pkg::B_MON_PKT + 31, 32'h1);
      rd(stats_pkg::B_MON_BYTE + 31, 32'h5dc);
      $display("monitor test done");
   endtask
   task automatic t_route();
      {vrf_rx_id, vrf_tx_id, nh_index, iprx_port, iprx_cat} = {2'h3, 2'h3, 10'h3ff, 4'h5, 3'h2};
      {head_block, tail_block} = {2'h3, 2'h3};
      for (int s = 6; s < 13; s++) ev(s);
      iprx_cat = 3'h5;
      ev(9);
      rd(stats_pkg::B_VRF_RX + 3, 32'h1);
      rd(stats_pkg::B_VRF_TX + 3, 32'h1);
      rd(stats_pkg::B_NEXT_HOP_HIT_COUNT + 1023, 32'h1);
      rd(stats_pkg::B_IPRX + 27, 32'h1);
      rd(stats_pkg::B_TAILDROP, 32'h1);
      rd(stats_pkg::B_HEAD + 3, 32'h1);
      rd(stats_pkg::B_TAIL + 3, 32'h1);
      $display("routing and datapath test done");
   endtask
   initial begin
      srst = 1'h1;
      {in_drop_reason, ieg_drop_reason, eeg_drop_reason, acl_ptr, ieg_drop_last} = '0;
      {ieg_drop_port, eeg_drop_port, mon_port, lut_index, lut_port, iprx_port, lut_set} = '0;
      {vrf_rx_id, vrf_tx_id, head_block, tail_block, mon_vid, lut_vid, rd_addr} = '0;
      {mon_len, nh_index, mon_pcp, iprx_cat, acl_count_en, lut_wr, rd_req} = '0;
      repeat (6) @(posedge clock);
      #1 srst = 1'h0;
      @(posedge clock);
      #1 `CHK(init_busy, 1'h1)
      for (int n = 0; n < 4000 && init_busy !== 1'h0; n++) @(posedge clock);
      #1 t_clear();
      t_ingress();
      t_egress();
      t_acl();
      t_mon();
      t_route();
      conclude();
   end
   // whole run is about 3000 cycles
   initial begin
      #200us;
      n_fail++;
      conclude();
   end
endmodule

// *** rtl/stats_pkg.sv ***
// Function
// (R1) counters are 32-bit and wrap, never saturate
// (R2) one ingress-port drop counter per reason code
// (R3) pre-destination discard bumps ingress-port reason counter
// (R4) all destinations filtered bumps no-destination-left counter
// (R5) ingress per-reason per-egress-port removal counters
// (R6) last port removed also bumps no-destination-left
// (R7) egress per-reason per-port drops, no replacement
// (R8) matching counting rule bumps pointed ACL counter
// (R9) four priority monitor sets; code picks the set by port/VLAN lookup, each set holding 8 PCP counters
// (R10) set chosen by port and VLAN lookup
// (R11) selected set adds packet and bytes at PCP
// (R12) count packets entering a VRF at ingress
// (R13) count packets leaving a VRF at egress
// (R14) count next hop hits for IP/MPLS
// (R15) per-port good IP receive in five categories
// (R16) count buffer admission tail-drops
// (R17) head and tail counters per pipeline block
// (R18) counters clear on reset, read without disturbing
package stats_pkg;
   localparam int CNT_W        = 32;
   localparam int NUM_PORTS    = 11;
   localparam int PORT_W       = 4;
   localparam int NUM_REASONS  = 64;
   localparam int REASON_W     = 6;
   localparam int NUM_ACL      = 64;
   localparam int ACL_W        = 6;
   localparam int NUM_SETS     = 4;
   localparam int SET_W        = 2;
   localparam int NUM_PCP      = 8;
   localparam int PCP_W        = 3;
   localparam int VID_W        = 12;
   localparam int LEN_W        = 15;
   localparam int NUM_VRF      = 4;
   localparam int VRF_W        = 2;
   localparam int NUM_NH       = 1024;
   localparam int NH_W         = 10;
   localparam int NUM_IPCAT    = 5;
   localparam int NUM_BLOCKS   = 4;
   // ip receive categories
   localparam int IP_UC_RX     = 0;
   localparam int IP_UC_ROUTED = 1;
   localparam int IP_MC_RX     = 2;
   localparam int IP_MC_ROUTED = 3;
   localparam int IP_MC_ACLDRP = 4;
   // flat counter map: base index of each group
   localparam int B_IN_DROP    = 0;
   localparam int B_NODEST     = B_IN_DROP + NUM_REASONS;
   localparam int B_IEG_DROP   = B_NODEST + 1;
   localparam int B_EEG_DROP   = B_IEG_DROP + NUM_REASONS * NUM_PORTS;
   localparam int B_ACL        = B_EEG_DROP + NUM_REASONS * NUM_PORTS;
   localparam int B_MON_PKT    = B_ACL + NUM_ACL;
   localparam int B_MON_BYTE   = B_MON_PKT + NUM_SETS * NUM_PCP;
   localparam int B_VRF_RX     = B_MON_BYTE + NUM_SETS * NUM_PCP;
   localparam int B_VRF_TX     = B_VRF_RX + NUM_VRF;
   localparam int B_NEXT_HOP_HIT_COUNT    = B_VRF_TX + NUM_VRF;
   localparam int B_IPRX       = B_NEXT_HOP_HIT_COUNT + NUM_NH;
   localparam int B_TAILDROP   = B_IPRX + NUM_IPCAT * NUM_PORTS;
   localparam int B_HEAD       = B_TAILDROP + 1;
   localparam int B_TAIL       = B_HEAD + NUM_BLOCKS;
   localparam int NUM_CNT      = B_TAIL + NUM_BLOCKS;
   localparam int ADDR_W       = 12;
   localparam int NUM_SRC      = 16;
   localparam int SRC_W        = 4;
   localparam int LUT_DEPTH    = 16;
   localparam int LUT_W        = 4;
   localparam logic [ADDR_W-1:0] RESET_LAST = 12'(NUM_CNT - 1);
   typedef enum logic [SRC_W-1:0] {
      SRC_IN_DROP, SRC_NODEST, SRC_IEG_DROP, SRC_EEG_DROP, SRC_ACL,
      SRC_MON, SRC_VRF_RX, SRC_VRF_TX, SRC_NEXT_HOP_HIT_COUNT, SRC_IPRX,
      SRC_TAILDROP, SRC_HEAD, SRC_TAIL, SRC_UNUSED0, SRC_UNUSED1,
      SRC_UNUSED2
   } src_t;
endpackage

// *** rtl/stats_ram.sv ***
// single-port-per-direction counter storage; read data registered
module stats_ram #(
   parameter int DEPTH  = 4096,
   parameter int AW     = 12,
   parameter int DW     = 32
) (
   input  wire logic          clock,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [DW-1:0] wr_data,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [DW-1:0] rd_data
);
   logic [DW-1:0] mem [DEPTH];

   // write port
   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // registered read
   always_ff @(posedge clock) begin
      rd_data <= mem[rd_addr];
   end
endmodule

// *** rtl/switch_statistics_counters.sv ***
// counter storage is a RAM updated by read-modify-write; each event source is held
// in a pending flag until the arbiter serves it, and its ready is low meanwhile.
module switch_statistics_counters (
   input  wire logic                               clock,
   input  wire logic                               srst,
   // ingress drop before destination assignment
   input  wire logic                               in_drop_valid,
   input  wire logic [stats_pkg::REASON_W-1:0]     in_drop_reason,
   output logic                                    in_drop_ready,
   // ingress removal of one destination port
   input  wire logic                               ieg_drop_valid,
   input  wire logic [stats_pkg::REASON_W-1:0]     ieg_drop_reason,
   input  wire logic [stats_pkg::PORT_W-1:0]       ieg_drop_port,
   input  wire logic                               ieg_drop_last,
   output logic                                    ieg_drop_ready,
   // all destinations filtered without a per-port event
   input  wire logic                               nodest_valid,
   output logic                                    nodest_ready,
   // egress pipeline drop
   input  wire logic                               eeg_drop_valid,
   input  wire logic [stats_pkg::REASON_W-1:0]     eeg_drop_reason,
   input  wire logic [stats_pkg::PORT_W-1:0]       eeg_drop_port,
   output logic                                    eeg_drop_ready,
   output logic                                    eeg_idle_gap,
   // access-control match
   input  wire logic                               acl_valid,
   input  wire logic                               acl_count_en,
   input  wire logic [stats_pkg::ACL_W-1:0]        acl_ptr,
   output logic                                    acl_ready,
   // priority monitor
   input  wire logic                               mon_valid,
   input  wire logic [stats_pkg::PORT_W-1:0]       mon_port,
   input  wire logic [stats_pkg::VID_W-1:0]        mon_vid,
   input  wire logic [stats_pkg::PCP_W-1:0]        mon_pcp,
   input  wire logic [stats_pkg::LEN_W-1:0]        mon_len,
   output logic                                    mon_ready,
   // monitor set lookup table write
   input  wire logic                               lut_wr,
   input  wire logic [stats_pkg::LUT_W-1:0]        lut_index,
   input  wire logic [stats_pkg::PORT_W-1:0]       lut_port,
   input  wire logic [stats_pkg::VID_W-1:0]        lut_vid,
   input  wire logic [stats_pkg::SET_W-1:0]        lut_set,
   // routing events
   input  wire logic                               vrf_rx_valid,
   input  wire logic [stats_pkg::VRF_W-1:0]        vrf_rx_id,
   output logic                                    vrf_rx_ready,
   input  wire logic                               vrf_tx_valid,
   input  wire logic [stats_pkg::VRF_W-1:0]        vrf_tx_id,
   output logic                                    vrf_tx_ready,
   input  wire logic                               nh_valid,
   input  wire logic [stats_pkg::NH_W-1:0]         nh_index,
   output logic                                    nh_ready,
   // good ip receive
   input  wire logic                               iprx_valid,
   input  wire logic [stats_pkg::PORT_W-1:0]       iprx_port,
   input  wire logic [2:0]                         iprx_cat,
   output logic                                    iprx_ready,
   // buffer admission tail-drop
   input  wire logic                               taildrop_valid,
   output logic                                    taildrop_ready,
   // pipeline block heads and tails
   input  wire logic                               head_valid,
   input  wire logic [1:0]                         head_block,
   output logic                                    head_ready,
   input  wire logic                               tail_valid,
   input  wire logic [1:0]                         tail_block,
   output logic                                    tail_ready,
   // software read port
   input  wire logic                               rd_req,
   input  wire logic [stats_pkg::ADDR_W-1:0]       rd_addr,
   output logic                                    rd_ack,
   output logic [stats_pkg::CNT_W-1:0]             rd_data,
   output logic                                    init_busy
);
   typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_READ, ST_WRITE} state_t;

   localparam int NS = stats_pkg::NUM_SRC;

   state_t                          state;
   logic [NS-1:0]                   pend;
   logic [NS-1:0]                   take;
   logic [NS-1:0]                   grant;
   logic [NS-1:0]                   done;
   logic [stats_pkg::ADDR_W-1:0]    addr [NS];
   logic [stats_pkg::CNT_W-1:0]     incr [NS];
   logic [stats_pkg::ADDR_W-1:0]    next_addr [NS];
   logic [stats_pkg::CNT_W-1:0]     next_incr [NS];
   logic [stats_pkg::ADDR_W-1:0]    cur_addr;
   logic [stats_pkg::CNT_W-1:0]     cur_incr;
   logic [stats_pkg::ADDR_W-1:0]    init_addr;
   logic [stats_pkg::ADDR_W-1:0]    ram_waddr;
   logic [stats_pkg::ADDR_W-1:0]    ram_raddr;
   logic [stats_pkg::CNT_W-1:0]     ram_wdata;
   logic [stats_pkg::CNT_W-1:0]     ram_rdata;
   logic                            ram_we;
   logic                            sw_turn;
   logic                            sw_serving;
   logic                            mon_byte_phase;
   logic                            any_pend;
   localparam int SRC_W_LOCAL = stats_pkg::SRC_W;
   logic [SRC_W_LOCAL-1:0]          sel;
   logic [NS-1:0]                   served;
   // monitor set lookup table
   logic [stats_pkg::PORT_W-1:0]    lut_p [stats_pkg::LUT_DEPTH];
   logic [stats_pkg::VID_W-1:0]     lut_v [stats_pkg::LUT_DEPTH];
   logic [stats_pkg::SET_W-1:0]     lut_s [stats_pkg::LUT_DEPTH];
   logic [stats_pkg::LUT_DEPTH-1:0] lut_ok;
   logic [stats_pkg::SET_W-1:0]     mon_set;
   logic                            mon_hit;

   // monitor set lookup: first matching valid entry picks the set
   always_comb begin
      mon_set = '0;
      mon_hit = 1'b0;
      for (int i = stats_pkg::LUT_DEPTH - 1; i >= 0; i--) begin
         if (lut_ok[i] && lut_p[i] == mon_port && lut_v[i] == mon_vid) begin
            mon_set = lut_s[i]; // R10
            mon_hit = 1'b1;
         end
      end
   end

   // lookup table storage; reset clears only the valid flags, not the entries
   always_ff @(posedge clock) begin
      if (srst) begin
         lut_ok <= '0;
      end else if (lut_wr) begin
         lut_ok[lut_index] <= 1'b1;
         lut_p[lut_index]  <= lut_port;
         lut_v[lut_index]  <= lut_vid;
         lut_s[lut_index]  <= lut_set;
      end
   end

   // counter address and increment of every event source
   always_comb begin
      for (int i = 0; i < NS; i++) begin
         take[i]      = 1'b0;
         next_addr[i] = '0;
         next_incr[i] = 32'h0000_0001;
      end
      take[stats_pkg::SRC_IN_DROP]      = in_drop_valid; // R3
      next_addr[stats_pkg::SRC_IN_DROP] = 12'(stats_pkg::B_IN_DROP) + 12'(in_drop_reason); // R2
      // a last-port removal or an explicit empty mask both reach this counter
      take[stats_pkg::SRC_NODEST]       = nodest_valid || (ieg_drop_valid && ieg_drop_last); // R4 R6
      next_addr[stats_pkg::SRC_NODEST]  = 12'(stats_pkg::B_NODEST);
      take[stats_pkg::SRC_IEG_DROP]     = ieg_drop_valid; // R5
      next_addr[stats_pkg::SRC_IEG_DROP] = 12'(stats_pkg::B_IEG_DROP)
         + 12'(ieg_drop_reason) * 12'(stats_pkg::NUM_PORTS) + 12'(ieg_drop_port);
      take[stats_pkg::SRC_EEG_DROP]     = eeg_drop_valid; // R7
      next_addr[stats_pkg::SRC_EEG_DROP] = 12'(stats_pkg::B_EEG_DROP)
         + 12'(eeg_drop_reason) * 12'(stats_pkg::NUM_PORTS) + 12'(eeg_drop_port);
      take[stats_pkg::SRC_ACL]          = acl_valid && acl_count_en; // R8
      next_addr[stats_pkg::SRC_ACL]     = 12'(stats_pkg::B_ACL) + 12'(acl_ptr);
      take[stats_pkg::SRC_MON]          = mon_valid && mon_hit; // R9
      next_addr[stats_pkg::SRC_MON]     = 12'(stats_pkg::B_MON_PKT)
         + 12'({mon_set, mon_pcp}); // R11
      next_incr[stats_pkg::SRC_MON]     = 32'(mon_len);
      take[stats_pkg::SRC_VRF_RX]       = vrf_rx_valid; // R12
      next_addr[stats_pkg::SRC_VRF_RX]  = 12'(stats_pkg::B_VRF_RX) + 12'(vrf_rx_id);
      take[stats_pkg::SRC_VRF_TX]       = vrf_tx_valid; // R13
      next_addr[stats_pkg::SRC_VRF_TX]  = 12'(stats_pkg::B_VRF_TX) + 12'(vrf_tx_id);
      take[stats_pkg::SRC_NEXT_HOP_HIT_COUNT]      = nh_valid; // R14
      next_addr[stats_pkg::SRC_NEXT_HOP_HIT_COUNT] = 12'(stats_pkg::B_NEXT_HOP_HIT_COUNT) + 12'(nh_index);
      take[stats_pkg::SRC_IPRX]         = iprx_valid && iprx_cat < 3'(stats_pkg::NUM_IPCAT); // R15
      next_addr[stats_pkg::SRC_IPRX]    = 12'(stats_pkg::B_IPRX)
         + 12'(iprx_cat) * 12'(stats_pkg::NUM_PORTS) + 12'(iprx_port);
      take[stats_pkg::SRC_TAILDROP]     = taildrop_valid; // R16
      next_addr[stats_pkg::SRC_TAILDROP] = 12'(stats_pkg::B_TAILDROP);
      take[stats_pkg::SRC_HEAD]         = head_valid; // R17
      next_addr[stats_pkg::SRC_HEAD]    = 12'(stats_pkg::B_HEAD) + 12'(head_block);
      take[stats_pkg::SRC_TAIL]         = tail_valid; // R17
      next_addr[stats_pkg::SRC_TAIL]    = 12'(stats_pkg::B_TAIL) + 12'(tail_block);
   end

   // a source is ready only when its slot is free; shared slots need both free
   assign in_drop_ready  = !pend[stats_pkg::SRC_IN_DROP] && state != ST_INIT;
   assign ieg_drop_ready = !pend[stats_pkg::SRC_IEG_DROP] && !pend[stats_pkg::SRC_NODEST]
                           && state != ST_INIT; // R6
   assign nodest_ready   = !pend[stats_pkg::SRC_NODEST] && !ieg_drop_valid && state != ST_INIT;
   assign eeg_drop_ready = !pend[stats_pkg::SRC_EEG_DROP] && state != ST_INIT;
   assign acl_ready      = !pend[stats_pkg::SRC_ACL] && state != ST_INIT;
   assign mon_ready      = !pend[stats_pkg::SRC_MON] && state != ST_INIT;
   assign vrf_rx_ready   = !pend[stats_pkg::SRC_VRF_RX] && state != ST_INIT;
   assign vrf_tx_ready   = !pend[stats_pkg::SRC_VRF_TX] && state != ST_INIT;
   assign nh_ready       = !pend[stats_pkg::SRC_NEXT_HOP_HIT_COUNT] && state != ST_INIT;
   assign iprx_ready     = !pend[stats_pkg::SRC_IPRX] && state != ST_INIT;
   assign taildrop_ready = !pend[stats_pkg::SRC_TAILDROP] && state != ST_INIT;
   assign head_ready     = !pend[stats_pkg::SRC_HEAD] && state != ST_INIT;
   assign tail_ready     = !pend[stats_pkg::SRC_TAIL] && state != ST_INIT;
   assign init_busy      = (state == ST_INIT);

   // accept per source: a pulse with its ready high
   logic [NS-1:0] accept;
   always_comb begin
      accept = '0;
      accept[stats_pkg::SRC_IN_DROP]  = take[stats_pkg::SRC_IN_DROP] && in_drop_ready;
      accept[stats_pkg::SRC_NODEST]   = take[stats_pkg::SRC_NODEST]
         && ((ieg_drop_valid && ieg_drop_last) ? ieg_drop_ready : nodest_ready); // R6
      accept[stats_pkg::SRC_IEG_DROP] = take[stats_pkg::SRC_IEG_DROP] && ieg_drop_ready;
      accept[stats_pkg::SRC_EEG_DROP] = take[stats_pkg::SRC_EEG_DROP] && eeg_drop_ready;
      accept[stats_pkg::SRC_ACL]      = take[stats_pkg::SRC_ACL] && acl_ready;
      accept[stats_pkg::SRC_MON]      = take[stats_pkg::SRC_MON] && mon_ready;
      accept[stats_pkg::SRC_VRF_RX]   = take[stats_pkg::SRC_VRF_RX] && vrf_rx_ready;
      accept[stats_pkg::SRC_VRF_TX]   = take[stats_pkg::SRC_VRF_TX] && vrf_tx_ready;
      accept[stats_pkg::SRC_NEXT_HOP_HIT_COUNT]  = take[stats_pkg::SRC_NEXT_HOP_HIT_COUNT] && nh_ready;
      accept[stats_pkg::SRC_IPRX]     = take[stats_pkg::SRC_IPRX] && iprx_ready;
      accept[stats_pkg::SRC_TAILDROP] = take[stats_pkg::SRC_TAILDROP] && taildrop_ready;
      accept[stats_pkg::SRC_HEAD]     = take[stats_pkg::SRC_HEAD] && head_ready;
      accept[stats_pkg::SRC_TAIL]     = take[stats_pkg::SRC_TAIL] && tail_ready;
   end

   // pending slots: a new accept wins over the completion of the same slot
   generate
      for (genvar g = 0; g < NS; g++) begin : g_slot
         always_ff @(posedge clock) begin
            if (srst) begin
               pend[g] <= 1'b0;
               addr[g] <= '0;
               incr[g] <= '0;
            end else if (accept[g]) begin
               pend[g] <= 1'b1;
               addr[g] <= next_addr[g];
               incr[g] <= next_incr[g];
            end else if (done[g]) begin
               pend[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // fixed priority pick of the lowest pending slot
   always_comb begin
      grant = '0;
      sel   = '0;
      for (int i = NS - 1; i >= 0; i--) begin
         if (pend[i]) begin
            grant = '0;
            grant[i] = 1'b1;
            sel = SRC_W_LOCAL'(i);
         end
      end
   end
   assign any_pend = |pend;

   // egress drop leaves an empty slot on transmit: flag it, never backfill
   always_ff @(posedge clock) begin
      if (srst) begin
         eeg_idle_gap <= 1'b0;
      end else begin
         eeg_idle_gap <= accept[stats_pkg::SRC_EEG_DROP]; // R7
      end
   end

   // update engine: init sweep, then alternate software reads with updates
   always_ff @(posedge clock) begin
      if (srst) begin
         state          <= ST_INIT;
         init_addr      <= '0;
         cur_addr       <= '0;
         cur_incr       <= '0;
         sw_turn        <= 1'b0;
         sw_serving     <= 1'b0;
         mon_byte_phase <= 1'b0;
         served         <= '0;
      end else begin
         unique case (state)
            ST_INIT: begin
               init_addr <= init_addr + 12'h001; // R18
               if (init_addr == stats_pkg::RESET_LAST) begin
                  state <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               sw_serving <= 1'b0;
               // software reads share the read port fairly with updates
               if (rd_req && (sw_turn || !any_pend)) begin
                  sw_serving <= 1'b1;
                  sw_turn    <= 1'b0;
                  state      <= ST_READ;
                  cur_addr   <= rd_addr;
               end else if (any_pend) begin
                  sw_turn  <= 1'b1;
                  state    <= ST_READ;
                  served   <= grant;
                  cur_addr <= addr[sel];
                  cur_incr <= (sel == stats_pkg::SRC_MON && !mon_byte_phase)
                              ? 32'h0000_0001 : incr[sel];
               end
            end
            ST_READ: begin
               state <= sw_serving ? ST_IDLE : ST_WRITE;
            end
            ST_WRITE: begin
               state <= ST_IDLE;
               // monitor does packet then byte counter at the same pcp, back to back so
               // no other source can slip between the two halves
               if (served[stats_pkg::SRC_MON] && !mon_byte_phase) begin
                  mon_byte_phase <= 1'b1;
                  state          <= ST_READ;
                  cur_addr       <= cur_addr + 12'(stats_pkg::NUM_SETS * stats_pkg::NUM_PCP);
                  cur_incr       <= incr[stats_pkg::SRC_MON]; // R11
               end else begin
                  mon_byte_phase <= 1'b0;
               end
            end
         endcase
      end
   end

   // a slot clears as its last write lands, so the next idle pick never repeats it
   assign done = (state == ST_WRITE && !(served[stats_pkg::SRC_MON] && !mon_byte_phase))
                 ? served : '0;

   // memory ports
   assign ram_raddr = cur_addr;
   assign ram_we    = (state == ST_INIT) || (state == ST_WRITE);
   assign ram_waddr = (state == ST_INIT) ? init_addr : ram_raddr;
   // plain modular add: wraps to zero past the top, no saturation
   assign ram_wdata = (state == ST_INIT) ? '0 : ram_rdata + cur_incr; // R1

   stats_ram #(
      .DEPTH   (stats_pkg::NUM_CNT),
      .AW      (stats_pkg::ADDR_W),
      .DW      (stats_pkg::CNT_W)
   ) i_stats_ram (
      .clock   (clock),
      .wr_en   (ram_we),
      .wr_addr (ram_waddr),
      .wr_data (ram_wdata),
      .rd_addr (ram_raddr),
      .rd_data (ram_rdata)
   );

   // read answer: data captured after the registered memory read
   always_ff @(posedge clock) begin
      if (srst) begin
         rd_ack  <= 1'b0;
         rd_data <= '0;
      end else begin
         rd_ack <= (state == ST_IDLE) && sw_serving; // R18
         if ((state == ST_IDLE) && sw_serving) begin
            rd_data <= ram_rdata;
         end
      end
   end
endmodule
